// [timer_unit_cfg.svh]
// Purpose: Register offsets, field positions, reset values and divider points of the timer unit.
// Assumes: APB byte addresses on an 8-bit address, one 32-bit word per register.
// Notes: Included by the timer unit only; the bench and the checker use literal offsets.
`ifndef TIMER_UNIT_CFG_SVH
`define TIMER_UNIT_CFG_SVH

`define OFF_FIXED_PRE 8'h00
`define OFF_FIXED_TMR 8'h04
`define OFF_WIDE_MODE 8'h08
`define OFF_WIDE_TMR 8'h0C
`define OFF_PULSE_MODE 8'h10
`define OFF_PULSE_PRE 8'h14
`define OFF_PULSE_TMR 8'h18
`define OFF_WAVE_MODE 8'h1C
`define OFF_WAVE_OUT 8'h20
`define OFF_WAVE_PRE 8'h24
`define OFF_WAVE_PRI 8'h28
`define OFF_WAVE_SEC 8'h2C
`define OFF_IRQ 8'h30

`define WIDE_EDGE_BIT 2
`define PULSE_EDGE_BIT 2
`define PULSE_AUX_BIT 3
`define PULSE_STOP_BIT 4
`define PULSE_SRC_BIT 5
`define WAVE_GEN_BIT 0
`define WAVE_SRC_BIT 1
`define WAVE_WCTL_BIT 2
`define WAVE_STOP_BIT 3
`define EXT_PRI_BIT 0
`define EXT_SEC_BIT 1
`define LEVEL_BIT 4

`define RST_MODE 8'h00
`define RST_BYTE 8'hFF
`define RST_WIDE 16'hFFFF
`define DIV_SLOW_LAST 4'hF
`define DIV_SLOW_HALF 4'h7

`endif

// [timer_unit_pkg.sv]
// Purpose: Types shared by the timer unit and its bench.
// Assumes: Nothing beyond the configuration header.
// Notes: The count step function is the common down-counter with reload.
package timer_unit_pkg;

    typedef enum logic [1:0] {
        WIDE_TIMER = 2'b00,
        WIDE_PERIOD = 2'b01,
        WIDE_EVENT = 2'b10,
        WIDE_HL = 2'b11
    } wide_mode_t;

    typedef enum logic [1:0] {
        PULSE_TIMER = 2'b00,
        PULSE_OUT = 2'b01,
        PULSE_EVENT = 2'b10,
        PULSE_WIDTH = 2'b11
    } pulse_mode_t;

    typedef enum logic [3:0] {
        WAVE_STOP = 4'b0001,
        WAVE_PRI = 4'b0010,
        WAVE_SEC = 4'b0100,
        WAVE_EXT = 4'b1000
    } wave_state_t;

    typedef struct packed {
        logic uf;
        logic [15:0] val;
    } count_step_t;

    typedef struct packed {
        logic pulse;
        logic capture;
        logic wide;
        logic fixed;
        logic wave;
    } irq_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_t;

    // A tick at zero underflows and reloads, so latch n divides by n+1.
    function automatic count_step_t step(input logic [15:0] cur, input logic [15:0] lat,
                                         input logic tick);
        count_step_t r;
        r.uf = tick && (cur == 16'h0000);
        r.val = !tick ? cur : (r.uf ? lat : cur - 16'h0001);
        return r;
    endfunction : step

endpackage : timer_unit_pkg

// [mcu_multi_timer_unit.sv]
// Purpose: Timer unit with fixed, wide, pulse and waveform timers behind an APB slave.
// Assumes: pclk is the oscillator; pins are asynchronous and pass two flip-flops.
// Notes: Interrupt flags are cleared by writing 0 to their bit; a set wins over a clear.
`include "timer_unit_cfg.svh"

module mcu_multi_timer_unit
    import timer_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic wide_capture_pin,
    input wire logic pulse_counter_pin_i,
    output logic pulse_counter_pin_o,
    output logic pulse_counter_pin_oe_n,
    output logic inverted_pulse_out_pin,
    output logic wave_out_pin,
    output irq_flags_t irq_request_reg_two
);

    apb_req_t req;
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

    wire access = psel & penable & pready;
    wire wr = access & req.write;
    wire rd = access & ~req.write;

    function automatic logic wr_hit(input logic [7:0] off);
        return wr && (req.addr == off);
    endfunction : wr_hit

    // Oscillator dividers: full ticks and the half-way ticks used for extension.
    logic [3:0] div_cnt;
    wire fast_full = div_cnt[0];
    wire fast_half = ~div_cnt[0];
    wire slow_full = (div_cnt == `DIV_SLOW_LAST);
    wire slow_half = (div_cnt == `DIV_SLOW_HALF);

    logic [1:0] cap_sync;
    logic [1:0] cnt_sync;
    logic cap_prev;
    logic cnt_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'h0;
            cap_sync <= 2'b00;
            cnt_sync <= 2'b00;
            cap_prev <= 1'b0;
            cnt_prev <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
            cap_sync <= {cap_sync[0], wide_capture_pin};
            cnt_sync <= {cnt_sync[0], pulse_counter_pin_i};
            cap_prev <= cap_sync[1];
            cnt_prev <= cnt_sync[1];
        end
    end

    // Fixed timer.
    logic [7:0] fix_pre_latch;
    logic [7:0] fix_pre;
    logic [7:0] fix_latch;
    logic [7:0] fix_cnt;
    count_step_t fix_pre_s;
    count_step_t fix_s;
    assign fix_pre_s = step({8'h00, fix_pre}, {8'h00, fix_pre_latch}, slow_full);
    assign fix_s = step({8'h00, fix_cnt}, {8'h00, fix_latch}, fix_pre_s.uf);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fix_pre_latch <= `RST_BYTE;
            fix_pre <= `RST_BYTE;
            fix_latch <= `RST_BYTE;
            fix_cnt <= `RST_BYTE;
        end else begin
            fix_pre_latch <= wr_hit(`OFF_FIXED_PRE) ? req.wdata[7:0] : fix_pre_latch;
            fix_pre <= wr_hit(`OFF_FIXED_PRE) ? req.wdata[7:0] : fix_pre_s.val[7:0];
            fix_latch <= wr_hit(`OFF_FIXED_TMR) ? req.wdata[7:0] : fix_latch;
            fix_cnt <= wr_hit(`OFF_FIXED_TMR) ? req.wdata[7:0] : fix_s.val[7:0];
        end
    end

    // Wide timer.
    logic [7:0] wide_mode_reg;
    logic [15:0] wide_latch;
    logic [15:0] wide_cnt;
    logic [15:0] wide_hold;
    logic wide_held;
    count_step_t wide_s;
    wide_mode_t wide_mode;
    assign wide_mode = wide_mode_t'(wide_mode_reg[1:0]);
    wire cap_rise = cap_sync[1] & ~cap_prev;
    wire cap_fall = ~cap_sync[1] & cap_prev;
    wire cap_sel = wide_mode_reg[`WIDE_EDGE_BIT] ? cap_fall : cap_rise;
    wire cap_any = cap_rise | cap_fall;
    wire wide_measure = (wide_mode == WIDE_PERIOD) || (wide_mode == WIDE_HL);
    wire wide_capture = wide_measure & ((wide_mode == WIDE_HL) ? cap_any : cap_sel);
    wire wide_tick = (wide_mode == WIDE_EVENT) ? cap_sel : slow_full;
    wire wide_read = rd && (req.addr == `OFF_WIDE_TMR);
    assign wide_s = step(wide_cnt, wide_latch, wide_tick);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_mode_reg <= `RST_MODE;
            wide_latch <= `RST_WIDE;
            wide_cnt <= `RST_WIDE;
            wide_hold <= `RST_WIDE;
            wide_held <= 1'b0;
        end else begin
            wide_mode_reg <= wr_hit(`OFF_WIDE_MODE) ? req.wdata[7:0] : wide_mode_reg;
            if (wr_hit(`OFF_WIDE_TMR)) begin
                wide_latch <= req.wdata[15:0];
                wide_cnt <= req.wdata[15:0];
            end else if (wide_capture) begin
                wide_cnt <= wide_latch;
            end else begin
                wide_cnt <= wide_s.val;
            end
            if (wide_capture) begin
                wide_hold <= wide_cnt;
                wide_held <= 1'b1;
            end else if (wide_read) begin
                wide_held <= 1'b0;
            end
        end
    end

    // Pulse timer.
    logic [7:0] pulse_mode_reg;
    logic [7:0] pulse_pre_latch;
    logic [7:0] pulse_pre;
    logic [7:0] pulse_latch;
    logic [7:0] pulse_cnt;
    logic pulse_level;
    count_step_t pulse_pre_s;
    count_step_t pulse_s;
    pulse_mode_t pulse_mode;
    assign pulse_mode = pulse_mode_t'(pulse_mode_reg[1:0]);
    wire pulse_edge_sw = pulse_mode_reg[`PULSE_EDGE_BIT];
    wire pin_rise = cnt_sync[1] & ~cnt_prev;
    wire pin_fall = ~cnt_sync[1] & cnt_prev;
    wire pin_edge = pulse_edge_sw ? pin_fall : pin_rise;
    wire pin_active = pulse_edge_sw ? ~cnt_sync[1] : cnt_sync[1];
    wire pulse_src = pulse_mode_reg[`PULSE_SRC_BIT] ? slow_full : fast_full;
    wire pulse_in = (pulse_mode == PULSE_EVENT) ? pin_edge :
                    (pulse_mode == PULSE_WIDTH) ? (pulse_src & pin_active) : pulse_src;
    wire pulse_run = pulse_in & ~pulse_mode_reg[`PULSE_STOP_BIT];
    wire pulse_out_mode = (pulse_mode == PULSE_OUT);
    assign pulse_pre_s = step({8'h00, pulse_pre}, {8'h00, pulse_pre_latch}, pulse_run);
    assign pulse_s = step({8'h00, pulse_cnt}, {8'h00, pulse_latch}, pulse_pre_s.uf);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_mode_reg <= `RST_MODE;
            pulse_pre_latch <= `RST_BYTE;
            pulse_pre <= `RST_BYTE;
            pulse_latch <= `RST_BYTE;
            pulse_cnt <= `RST_BYTE;
            pulse_level <= 1'b1;
        end else begin
            pulse_mode_reg <= wr_hit(`OFF_PULSE_MODE) ? req.wdata[7:0] : pulse_mode_reg;
            pulse_pre_latch <= wr_hit(`OFF_PULSE_PRE) ? req.wdata[7:0] : pulse_pre_latch;
            pulse_pre <= wr_hit(`OFF_PULSE_PRE) ? req.wdata[7:0] : pulse_pre_s.val[7:0];
            pulse_latch <= wr_hit(`OFF_PULSE_TMR) ? req.wdata[7:0] : pulse_latch;
            pulse_cnt <= wr_hit(`OFF_PULSE_TMR) ? req.wdata[7:0] : pulse_s.val[7:0];
            if (!pulse_out_mode) begin
                pulse_level <= ~pulse_edge_sw;
            end else if (pulse_s.uf) begin
                pulse_level <= ~pulse_level;
            end
        end
    end

    // Waveform timer.
    logic [7:0] wave_timer_mode_reg;
    logic [7:0] waveform_output_ctrl_reg;
    logic [7:0] wave_primary_latch;
    logic [7:0] wave_secondary_latch;
    logic [7:0] act_sec;
    logic act_ext_pri;
    logic act_ext_sec;
    logic [7:0] wave_pre_latch;
    logic [7:0] wave_pre;
    logic [7:0] wave_cnt;
    logic wave_phase;
    logic ext_to_sec;
    logic wave_sec_out;
    wave_state_t wave_state;
    wave_state_t next_wave_state;
    count_step_t wave_pre_s;
    count_step_t wave_s;
    wire wave_stop = wave_timer_mode_reg[`WAVE_STOP_BIT];
    wire wave_gen = wave_timer_mode_reg[`WAVE_GEN_BIT];
    wire wave_level = waveform_output_ctrl_reg[`LEVEL_BIT];
    wire wave_full = wave_timer_mode_reg[`WAVE_SRC_BIT] ? slow_full : fast_full;
    wire wave_half = wave_timer_mode_reg[`WAVE_SRC_BIT] ? slow_half : fast_half;
    // Each extension toggles the count clock between the full and the half-way phase.
    wire wave_count_clock = wave_phase ? wave_half : wave_full;
    wire wave_other = wave_phase ? wave_full : wave_half;
    wire wave_running = (wave_state == WAVE_PRI) || (wave_state == WAVE_SEC);
    wire wave_in_pri = (wave_state == WAVE_PRI);
    wire [7:0] wave_reload = (wave_in_pri && wave_gen) ? act_sec : wave_primary_latch;
    wire wave_ext_now = wave_in_pri ? act_ext_pri : act_ext_sec;
    wire wave_pri_wr = wr_hit(`OFF_WAVE_PRI);
    wire wave_load_cnt = wave_pri_wr &&
                         (wave_stop || !wave_timer_mode_reg[`WAVE_WCTL_BIT]);
    wire wave_ext_done = (wave_state == WAVE_EXT) && (next_wave_state != WAVE_EXT)
                         && !wave_stop;
    assign wave_pre_s = step({8'h00, wave_pre}, {8'h00, wave_pre_latch},
                             wave_count_clock & wave_running);
    assign wave_s = step({8'h00, wave_cnt}, {8'h00, wave_reload}, wave_pre_s.uf);

    always_comb begin
        next_wave_state = wave_state;
        case (wave_state)
            WAVE_STOP: begin
                if (!wave_stop) begin
                    next_wave_state = WAVE_PRI;
                end
            end
            WAVE_PRI, WAVE_SEC: begin
                if (wave_stop) begin
                    next_wave_state = WAVE_STOP;
                end else if (wave_s.uf && wave_gen) begin
                    next_wave_state = wave_ext_now ? WAVE_EXT :
                                      (wave_in_pri ? WAVE_SEC : WAVE_PRI);
                end
            end
            WAVE_EXT: begin
                if (wave_stop) begin
                    next_wave_state = WAVE_STOP;
                end else if (wave_other) begin
                    next_wave_state = ext_to_sec ? WAVE_SEC : WAVE_PRI;
                end
            end
            default: begin
                next_wave_state = WAVE_STOP;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_state <= WAVE_STOP;
            wave_timer_mode_reg <= `RST_MODE;
            waveform_output_ctrl_reg <= `RST_MODE;
            wave_primary_latch <= `RST_BYTE;
            wave_secondary_latch <= `RST_BYTE;
            act_sec <= `RST_BYTE;
            act_ext_pri <= 1'b0;
            act_ext_sec <= 1'b0;
            wave_pre_latch <= `RST_BYTE;
            wave_pre <= `RST_BYTE;
            wave_cnt <= `RST_BYTE;
            wave_phase <= 1'b0;
            ext_to_sec <= 1'b0;
            wave_sec_out <= 1'b0;
        end else begin
            wave_state <= next_wave_state;
            wave_timer_mode_reg <= wr_hit(`OFF_WAVE_MODE) ? req.wdata[7:0] : wave_timer_mode_reg;
            waveform_output_ctrl_reg <= wr_hit(`OFF_WAVE_OUT) ? req.wdata[7:0]
                                                              : waveform_output_ctrl_reg;
            wave_secondary_latch <= wr_hit(`OFF_WAVE_SEC) ? req.wdata[7:0] : wave_secondary_latch;
            if (wave_pri_wr) begin
                wave_primary_latch <= req.wdata[7:0];
                act_sec <= wave_secondary_latch;
                act_ext_pri <= waveform_output_ctrl_reg[`EXT_PRI_BIT];
                act_ext_sec <= waveform_output_ctrl_reg[`EXT_SEC_BIT];
            end
            wave_pre_latch <= wr_hit(`OFF_WAVE_PRE) ? req.wdata[7:0] : wave_pre_latch;
            wave_pre <= wr_hit(`OFF_WAVE_PRE) ? req.wdata[7:0] : wave_pre_s.val[7:0];
            if (wave_load_cnt) begin
                wave_cnt <= req.wdata[7:0];
            end else if (wave_ext_done) begin
                wave_cnt <= ext_to_sec ? act_sec : wave_primary_latch;
            end else begin
                wave_cnt <= wave_s.val[7:0];
            end
            if (next_wave_state == WAVE_EXT && wave_state != WAVE_EXT) begin
                ext_to_sec <= wave_in_pri;
            end
            if (next_wave_state == WAVE_STOP) begin
                wave_phase <= 1'b0;
            end else if (wave_ext_done) begin
                wave_phase <= ~wave_phase;
            end
            if (next_wave_state == WAVE_SEC) begin
                wave_sec_out <= 1'b1;
            end else if (next_wave_state != WAVE_EXT) begin
                wave_sec_out <= 1'b0;
            end
        end
    end

    // Interrupt request flags and register read path.
    irq_flags_t irq_set;
    irq_flags_t irq_clr;
    assign irq_set = '{pulse: pulse_s.uf, capture: wide_capture, wide: wide_s.uf,
                       fixed: fix_s.uf, wave: wave_s.uf};
    assign irq_clr = wr_hit(`OFF_IRQ) ? irq_flags_t'(~req.wdata[4:0]) : irq_flags_t'(5'h00);

    wire [7:0] a = req.addr;
    wire [15:0] wide_view = wide_held ? wide_hold : wide_cnt;
    wire hit = (a <= `OFF_IRQ) && (a[1:0] == 2'b00);
    wire [31:0] rd_mux =
        (a == `OFF_FIXED_PRE) ? {24'h00_0000, fix_pre} :
        (a == `OFF_FIXED_TMR) ? {24'h00_0000, fix_cnt} :
        (a == `OFF_WIDE_MODE) ? {24'h00_0000, wide_mode_reg} :
        (a == `OFF_WIDE_TMR) ? {16'h0000, wide_view} :
        (a == `OFF_PULSE_MODE) ? {24'h00_0000, pulse_mode_reg} :
        (a == `OFF_PULSE_PRE) ? {24'h00_0000, pulse_pre} :
        (a == `OFF_PULSE_TMR) ? {24'h00_0000, pulse_cnt} :
        (a == `OFF_WAVE_MODE) ? {24'h00_0000, wave_timer_mode_reg} :
        (a == `OFF_WAVE_OUT) ? {24'h00_0000, waveform_output_ctrl_reg} :
        (a == `OFF_WAVE_PRE) ? {24'h00_0000, wave_pre} :
        (a == `OFF_WAVE_PRI) ? {24'h00_0000, wave_cnt} :
        (a == `OFF_IRQ) ? {27'h000_0000, irq_request_reg_two} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request_reg_two <= irq_flags_t'(5'h00);
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pulse_counter_pin_o <= 1'b1;
            pulse_counter_pin_oe_n <= 1'b1;
            inverted_pulse_out_pin <= 1'b0;
            wave_out_pin <= 1'b0;
        end else begin
            irq_request_reg_two <= (irq_request_reg_two & ~irq_clr) | irq_set;
            pready <= psel & ~penable;
            prdata <= (psel & ~penable & ~req.write & hit) ? rd_mux : 32'h0000_0000;
            pslverr <= psel & ~penable & ~hit;
            pulse_counter_pin_o <= pulse_level;
            pulse_counter_pin_oe_n <= ~pulse_out_mode;
            inverted_pulse_out_pin <= pulse_out_mode & pulse_mode_reg[`PULSE_AUX_BIT]
                                      & ~pulse_level;
            wave_out_pin <= (!wave_gen || wave_state == WAVE_STOP) ? wave_level :
                            (wave_sec_out ? wave_level : ~wave_level);
        end
    end

endmodule : mcu_multi_timer_unit

// [timer_unit_assertions.sv]
// Purpose: Concurrent checks on the timer unit ports.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to the design from the bench top.
module timer_unit_checker
    import timer_unit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic pulse_counter_pin_o,
    input wire logic pulse_counter_pin_oe_n,
    input wire logic inverted_pulse_out_pin,
    input wire logic wave_out_pin,
    input wire irq_flags_t irq_request_reg_two
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_ready_in_access: assert property (pready |-> psel && penable && !$past(penable))
        else $error("pready outside access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (pready && (paddr > 8'h30 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped address accepted");
    a_mapped_ok: assert property (pready && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped address refused");
    a_quiet_data: assert property (!pready || pwrite || pslverr |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_clear_by_write: assert property (
        (|($past(irq_request_reg_two) & ~irq_request_reg_two)) |->
        $past(psel && penable && pwrite && paddr == 8'h30)) else $error("flag fell alone");
    a_clear_by_zero: assert property (
        !(|($past(irq_request_reg_two) & ~irq_request_reg_two & $past(pwdata[4:0]))))
        else $error("flag cleared by one");
    a_aux_inverse: assert property (
        inverted_pulse_out_pin |-> !pulse_counter_pin_o && !pulse_counter_pin_oe_n)
        else $error("aux pin not inverse");
    c_unmapped: cover property (pslverr);
    c_capture: cover property ($rose(irq_request_reg_two.capture));
    c_wave_toggle: cover property ($changed(wave_out_pin));
    c_aux: cover property (inverted_pulse_out_pin);
endmodule : timer_unit_checker

// [pin_source.sv]
// Purpose: External square-wave source feeding one timer pin.
// Assumes: The source is synchronous to pclk.
// Notes: Half period comes from the bench, so edges can be fast or slow.
module pin_source
(
    input wire logic pclk,
    input wire logic run,
    input wire logic [7:0] half,
    output logic pin
);
    logic [7:0] cnt;
    initial begin
        pin = 1'b0;
        cnt = 8'h0;
    end
    always @(posedge pclk) begin
        if (run) begin
            if (cnt + 8'h1 >= half) begin
                cnt <= 8'h0;
                pin <= ~pin;
            end else begin
                cnt <= cnt + 8'h1;
            end
        end
    end
endmodule : pin_source

// [tb_mcu_multi_timer_unit.sv]
// Purpose: Self-checking bench of the timer unit over APB and its pins.
// Assumes: pclk runs at 20 MHz; pins come from two pin_source models.
// Notes: The APB driver queues each expected answer and a watcher compares it.
module tb_mcu_multi_timer_unit
    import timer_unit_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [31:0] e; logic [31:0] m; logic er;} note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wide_capture_pin, ppin;
    logic pulse_counter_pin_i, pulse_counter_pin_o, pulse_counter_pin_oe_n;
    logic inverted_pulse_out_pin, wave_out_pin, crun, prun;
    logic [7:0] paddr, hw, obs;
    logic [31:0] pwdata, prdata;
    irq_flags_t irq_request_reg_two;
    int seed, h, err_count, num_checks, cyc;
    note_t q[$];
    note_t nt;
    logic [7:0] ro [6] = '{8'h08, 8'h10, 8'h1C, 8'h20, 8'h2C, 8'h30};
    logic [7:0] pm [4] = '{8'h00, 8'h20, 8'h02, 8'h06};
    logic [7:0] wm [5] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h05};
    int wb [5] = '{2, 3, 3, 2, 3};
    // The shared pin carries the design's level only while its output is enabled.
    assign pulse_counter_pin_i = pulse_counter_pin_oe_n ? ppin : pulse_counter_pin_o;
    assign obs = {irq_request_reg_two, pready, pulse_counter_pin_o, wave_out_pin};
    mcu_multi_timer_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .wide_capture_pin, .pulse_counter_pin_i,
        .pulse_counter_pin_o, .pulse_counter_pin_oe_n, .inverted_pulse_out_pin, .wave_out_pin,
        .irq_request_reg_two);
    pin_source cap_src (.pclk, .run(crun), .half(hw), .pin(wide_capture_pin));
    pin_source cnt_src (.pclk, .run(prun), .half(hw), .pin(ppin));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            nt = q.pop_front();
            chk("prdata", nt.e, prdata & nt.m);
            chk("pslverr", {31'h0, nt.er}, {31'h0, pslverr});
        end
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic wait_lvl(input int k, input logic v, output int n);
        n = 0;
        while (obs[k] !== v) begin
            @(posedge pclk);
            n++;
            if (n > 4000) begin
                err_count++;
                $display("unexpected wait expected %0d seen %0d", v, obs[k]);
                complete_run();
            end
        end
    endtask : wait_lvl
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic er);
        int n;
        q.push_back({e, m, er});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        wait_lvl(2, 1'b1, n);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'hFFFF_FFFF, 1'b0);
    endtask : wr
    task automatic irq_period(input int b, input int exp);
        int n;
        int t;
        t = 0;
        repeat (2) begin
            wr(8'h30, {27'h0, ~(5'h01 << b)});
            wait_lvl(b + 3, 1'b1, n);
            t = cyc - t;
        end
        chk("irq period", exp, t);
    endtask : irq_period
    task automatic width(input int s, input logic v, input int exp);
        int n;
        repeat (2) begin
            wait_lvl(s, ~v, n);
            wait_lvl(s, v, n);
            wait_lvl(s, ~v, n);
        end
        chk("pin width", exp, n);
    endtask : width
    initial begin
        int pe [4];
        int we [5];
        seed = 89;
        h = 8 + ($random(seed) & 7);
        hw = 8'(h);
        pe = '{8, 64, 8 * h, 8 * h};
        we = '{32, 2 * h, h, 4 * h, 2 * h};
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        crun = 1'b0;
        prun = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ro[i]) apb(1'b0, ro[i], 32'h0, 32'h0, 32'hFF, 1'b0);
        wr(8'h30, 32'h1F);
        apb(1'b0, 8'h30, 32'h0, 32'h0, 32'h1F, 1'b0);
        apb(1'b0, 8'h34, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
        apb(1'b1, 8'h02, 32'h5, 32'h0, 32'hFFFF_FFFF, 1'b1);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h3);
        irq_period(1, 64);
        wr(8'h24, 32'h0);
        wr(8'h28, 32'h4);
        irq_period(0, 10);
        wr(8'h1C, 32'h2);
        irq_period(0, 80);
        wr(8'h1C, 32'h9);
        wr(8'h20, 32'h0);
        repeat (4) @(posedge pclk);
        chk("idle level", 32'h0, {31'h0, wave_out_pin});
        wr(8'h2C, 32'h2);
        wr(8'h28, 32'h4);
        wr(8'h1C, 32'h5);
        width(0, 1'b1, 10);
        width(0, 1'b0, 6);
        wr(8'h1C, 32'hD);
        wr(8'h20, 32'h10);
        repeat (4) @(posedge pclk);
        chk("idle level", 32'h1, {31'h0, wave_out_pin});
        wr(8'h28, 32'h4);
        wr(8'h1C, 32'h5);
        width(0, 1'b0, 10);
        wr(8'h20, 32'h11);
        wr(8'h2C, 32'h5);
        width(0, 1'b1, 6);
        wr(8'h28, 32'h4);
        width(0, 1'b0, 11);
        width(0, 1'b1, 12);
        wr(8'h14, 32'h0);
        wr(8'h18, 32'h3);
        prun <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(8'h10, {24'h0, pm[k]});
            irq_period(4, pe[k]);
        end
        prun <= 1'b0;
        wr(8'h10, 32'h1D);
        repeat (4) @(posedge pclk);
        chk("pulse start", 32'h0, {31'h0, pulse_counter_pin_o});
        chk("aux pin", 32'h1, {31'h0, inverted_pulse_out_pin});
        wr(8'h10, 32'h10);
        wr(8'h10, 32'h19);
        repeat (4) @(posedge pclk);
        chk("pulse start", 32'h1, {31'h0, pulse_counter_pin_o});
        wr(8'h10, 32'h09);
        width(1, 1'b1, 8);
        width(1, 1'b0, 8);
        wr(8'h10, 32'h19);
        wr(8'h30, 32'h0F);
        repeat (40) @(posedge pclk);
        chk("stopped flag", 32'h0, {31'h0, irq_request_reg_two.pulse});
        crun <= 1'b1;
        wr(8'h0C, 32'h1);
        for (int k = 0; k < 5; k++) begin
            wr(8'h08, {24'h0, wm[k]});
            irq_period(wb[k], we[k]);
        end
        complete_run();
    end
endmodule : tb_mcu_multi_timer_unit
bind mcu_multi_timer_unit timer_unit_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .pulse_counter_pin_o, .pulse_counter_pin_oe_n,
    .inverted_pulse_out_pin, .wave_out_pin, .irq_request_reg_two);
